// ===== inc/pin_remap_pkg.sv
package pin_remap_pkg;

	// remap option bit positions
	localparam int REMAP_ADC_TRIG = 0;
	localparam int REMAP_CLK_OUT = 2;
	localparam int REMAP_BREAK = 3;
	localparam int REMAP_ADV_TIMER = 5;
	localparam int REMAP_I2C = 6;
	localparam int REMAP_GP_TIMER = 1;
	localparam int REMAP_BEEPER = 7;
	localparam int REMAP_WIDTH = 8;

	// register byte addresses (all chosen)
	localparam logic [7:0] ADDR_REMAP_STATUS = 8'h00;
	localparam logic [7:0] ADDR_SPEED_CTRL = 8'h04;
	localparam logic [7:0] ADDR_PAD_CTRL = 8'h08;
	localparam logic [7:0] ADDR_PIN_STATUS = 8'h0C;

	// reset values of speed selects (1 = fast), remap bits and pad pull-up
	localparam logic [7:0] SPEED_SLOW_RESET = 8'h00;
	localparam logic SPEED_FAST_RESET = 1'b1;
	localparam logic [7:0] REMAP_RESET = 8'h00;
	localparam logic PAD_PULLUP_RESET = 1'b1;

	// axi response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// alternate function request from one peripheral
	typedef struct packed {
		logic en;
		logic oe;
		logic out;
	} alt_out_type;

	// resolved drive for one pin
	typedef struct packed {
		logic oe;
		logic out;
	} pin_drive_type;

endpackage

// ===== logic/pin_remap.sv
`timescale 1ns/1ps
module pin_remap
	import pin_remap_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	// option byte remap bits, static during reset
	input wire logic [7:0] i_remap_option,
	// axi4-lite slave
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// gpio port drive for affected pins (general purpose path)
	input wire pin_drive_type i_gpio_a3,
	input wire pin_drive_type i_gpio_d2,
	input wire pin_drive_type i_gpio_d0,
	input wire pin_drive_type i_gpio_d4,
	input wire pin_drive_type i_gpio_b2,
	input wire pin_drive_type i_gpio_b1,
	input wire pin_drive_type i_gpio_b0,
	input wire pin_drive_type i_gpio_b5,
	input wire pin_drive_type i_gpio_b4,
	input wire pin_drive_type i_gpio_c1,
	// alternate function outputs from peripherals
	input wire alt_out_type i_gp_timer_b_channel1,
	input wire alt_out_type i_gp_timer_a_channel3,
	input wire alt_out_type i_gp_timer_b_channel2,
	input wire alt_out_type i_gp_timer_a_channel1,
	input wire alt_out_type i_configurable_clock_output,
	input wire alt_out_type i_beeper_output,
	input wire alt_out_type i_advanced_timer_complement_out1,
	input wire alt_out_type i_advanced_timer_complement_out2,
	input wire alt_out_type i_advanced_timer_complement_out3,
	input wire alt_out_type i_i2c_sda,
	input wire alt_out_type i_i2c_scl,
	// input-side peripheral enables
	input wire logic i_break_en,
	input wire logic i_ext_trigger_en,
	input wire logic i_adc_trigger_en,
	// pin inputs (async)
	input wire logic i_pin_a3,
	input wire logic i_pin_d2,
	input wire logic i_pin_d0,
	input wire logic i_pin_d3,
	input wire logic i_pin_b3,
	input wire logic i_pin_b5,
	input wire logic i_pin_b4,
	input wire logic i_pin_e3,
	input wire logic i_pin_e2,
	input wire logic i_pin_e1,
	input wire logic i_pin_e0_unused,
	input wire logic i_pin_port_d_bit7,
	// top level interrupt enable from port control
	input wire logic i_port_d_bit7_int_en,
	// halt / oscillator state
	input wire logic i_halt,
	input wire logic i_hse_wakeup,
	input wire logic i_hse_off,
	input wire logic i_osc_pullup_option,
	// pad outputs
	output pin_drive_type o_pad_a3,
	output pin_drive_type o_pad_d2,
	output pin_drive_type o_pad_d0,
	output pin_drive_type o_pad_d4,
	output pin_drive_type o_pad_b2,
	output pin_drive_type o_pad_b1,
	output pin_drive_type o_pad_b0,
	output pin_drive_type o_pad_b5,
	output pin_drive_type o_pad_b4,
	output pin_drive_type o_pad_e2,
	output pin_drive_type o_pad_e1,
	output pin_drive_type o_pad_e0,
	output pin_drive_type o_pad_c1,
	// sampled alternate inputs to peripherals
	output logic o_gp_timer_b_channel1_in,
	output logic o_advanced_timer_break_input,
	output logic o_advanced_timer_external_trigger,
	output logic o_adc_external_trigger,
	output logic o_i2c_sda_in,
	output logic o_i2c_scl_in,
	// pad control
	output logic [7:0] o_speed_class_slow_default_fast,
	output logic o_speed_class_fast_default_fast,
	output logic o_debug_data_pin_pullup,
	output logic o_debug_data_pin_oe,
	output logic o_port_f_bit4_pullup,
	output logic o_top_level_interrupt,
	output logic o_port_d_bit7_port_int,
	output logic o_oscillator_input_pad_in_en,
	output logic o_oscillator_input_pad_out_en,
	output logic o_oscillator_input_pad_pullup
);

	logic [7:0] remap_r;
	logic [7:0] speed_slow_r;
	logic speed_fast_r;
	logic osc_pull_r;
	logic [1:0] sync_in_r [0:11];
	logic [11:0] pin_s;
	logic tli_prev_r;
	logic [31:0] rdata_nxt;
	logic aw_hold_r;
	logic w_hold_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_go;
	logic wr_hit;
	logic rd_hit;
	logic rem_gp;
	logic rem_i2c;
	logic rem_adv;
	logic rem_brk;
	logic rem_cco;
	logic rem_adc;
	logic rem_beeper_output;

	// peripheral output gated by its enable
	function automatic pin_drive_type alt_drv(input alt_out_type a);
		alt_drv.oe = a.en & a.oe;
		alt_drv.out = a.out;
	endfunction

	// alternate drive wins when active, gpio keeps its path otherwise
	function automatic pin_drive_type mux_drv(input logic sel,
		input alt_out_type a, input pin_drive_type g);
		pin_drive_type d;
		d = alt_drv(a);
		mux_drv = (sel && d.oe) ? d : g;
	endfunction

	// two-flop synchronisers for pin inputs
	assign pin_s = {sync_in_r[11][1], sync_in_r[10][1], sync_in_r[9][1],
		sync_in_r[8][1], sync_in_r[7][1], sync_in_r[6][1],
		sync_in_r[5][1], sync_in_r[4][1], sync_in_r[3][1],
		sync_in_r[2][1], sync_in_r[1][1], sync_in_r[0][1]};

	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			for (int k = 0; k < 12; k++)
				sync_in_r[k] <= 2'h0;
		else
		begin
			sync_in_r[0] <= {sync_in_r[0][0], i_pin_a3};
			sync_in_r[1] <= {sync_in_r[1][0], i_pin_d2};
			sync_in_r[2] <= {sync_in_r[2][0], i_pin_d0};
			sync_in_r[3] <= {sync_in_r[3][0], i_pin_d3};
			sync_in_r[4] <= {sync_in_r[4][0], i_pin_b3};
			sync_in_r[5] <= {sync_in_r[5][0], i_pin_b5};
			sync_in_r[6] <= {sync_in_r[6][0], i_pin_b4};
			sync_in_r[7] <= {sync_in_r[7][0], i_pin_e3};
			sync_in_r[8] <= {sync_in_r[8][0], i_pin_e2};
			sync_in_r[9] <= {sync_in_r[9][0], i_pin_e1};
			sync_in_r[10] <= {sync_in_r[10][0], i_pin_e0_unused};
			sync_in_r[11] <= {sync_in_r[11][0], i_pin_port_d_bit7};
		end
	end

	// remap bits caught once after release, then frozen
	logic remap_loaded_r;
	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			remap_r <= REMAP_RESET;
			remap_loaded_r <= 1'b0;
		end
		else if (!remap_loaded_r)
		begin
			remap_r <= i_remap_option;
			remap_loaded_r <= 1'b1;
		end
	end

	assign rem_adc = remap_r[REMAP_ADC_TRIG];
	assign rem_gp = remap_r[REMAP_GP_TIMER];
	assign rem_cco = remap_r[REMAP_CLK_OUT];
	assign rem_brk = remap_r[REMAP_BREAK];
	assign rem_adv = remap_r[REMAP_ADV_TIMER];
	assign rem_i2c = remap_r[REMAP_I2C];
	assign rem_beeper_output = remap_r[REMAP_BEEPER];

	// timer b ch1 to a3, timer a ch3 to d2 when remapped, swapped otherwise
	// gpio path kept when alternate idle
	assign o_pad_a3 = rem_gp ? mux_drv(1'b1, i_gp_timer_b_channel1, i_gpio_a3)
		: mux_drv(1'b1, i_gp_timer_a_channel3, i_gpio_a3);
	assign o_pad_d2 = rem_gp ? mux_drv(1'b1, i_gp_timer_a_channel3, i_gpio_d2)
		: mux_drv(1'b1, i_gp_timer_b_channel1, i_gpio_d2);
	assign o_gp_timer_b_channel1_in = i_gp_timer_b_channel1.en
		& (rem_gp ? pin_s[0] : pin_s[1]);

	// d0 select: break, clock out, or timer b ch2
	assign o_pad_d0 = rem_cco
		? mux_drv(1'b1, i_configurable_clock_output, i_gpio_d0)
		: mux_drv(!rem_brk, i_gp_timer_b_channel2, i_gpio_d0);
	assign o_pad_e0 = rem_cco ? '0
		: alt_drv(i_configurable_clock_output);
	assign o_advanced_timer_break_input = i_break_en
		& (rem_brk ? pin_s[2] : pin_s[7]);

	// adc trigger from d3 only when remapped
	assign o_adc_external_trigger = i_adc_trigger_en & rem_adc & pin_s[3];

	// beeper onto d4, else timer a ch1
	assign o_pad_d4 = rem_beeper_output
		? mux_drv(1'b1, i_beeper_output, i_gpio_d4)
		: mux_drv(1'b1, i_gp_timer_a_channel1, i_gpio_d4);

	// complementary outputs and trigger on port b
	assign o_pad_b2 = mux_drv(rem_adv, i_advanced_timer_complement_out3,
		i_gpio_b2);
	assign o_pad_b1 = mux_drv(rem_adv, i_advanced_timer_complement_out2,
		i_gpio_b1);
	assign o_pad_b0 = mux_drv(rem_adv, i_advanced_timer_complement_out1,
		i_gpio_b0);
	assign o_advanced_timer_external_trigger = i_ext_trigger_en & rem_adv
		& pin_s[4];
	assign o_pad_c1 = i_gpio_c1;

	// i2c onto b5 / b4, default pins released
	assign o_pad_b5 = mux_drv(rem_i2c, i_i2c_sda, i_gpio_b5);
	assign o_pad_b4 = mux_drv(rem_i2c, i_i2c_scl, i_gpio_b4);
	assign o_pad_e2 = rem_i2c ? '0 : alt_drv(i_i2c_sda);
	assign o_pad_e1 = rem_i2c ? '0 : alt_drv(i_i2c_scl);
	assign o_i2c_sda_in = i_i2c_sda.en & (rem_i2c ? pin_s[5] : pin_s[8]);
	assign o_i2c_scl_in = i_i2c_scl.en & (rem_i2c ? pin_s[6] : pin_s[9]);

	// debug pin held as pulled-up input
	assign o_debug_data_pin_pullup = 1'b1;
	assign o_debug_data_pin_oe = 1'b0;
	// pull-up on analog twelve pin in reset
	// elsewhere reset view uses REMAP_RESET routing and cleared pin samples
	assign o_port_f_bit4_pullup = !i_arst_n;

	assign o_speed_class_slow_default_fast = speed_slow_r;
	assign o_speed_class_fast_default_fast = speed_fast_r;

	// edge on top level pin raises top level interrupt
	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			tli_prev_r <= 1'b0;
		else
			tli_prev_r <= pin_s[11];
	end
	assign o_top_level_interrupt = i_port_d_bit7_int_en
		& (pin_s[11] ^ tli_prev_r);
	assign o_port_d_bit7_port_int = 1'b0;

	assign o_oscillator_input_pad_in_en = !i_halt;
	assign o_oscillator_input_pad_out_en = !i_halt;
	assign o_oscillator_input_pad_pullup = !i_halt ? osc_pull_r
		: i_hse_wakeup ? 1'b0
		: i_hse_off ? i_osc_pullup_option : osc_pull_r;

	// axi write: address and data in either order
	assign o_awready = !aw_hold_r && !o_bvalid;
	assign o_wready = !w_hold_r && !o_bvalid;
	assign wr_go = aw_hold_r && w_hold_r && !o_bvalid;
	assign wr_hit = (awaddr_r == ADDR_SPEED_CTRL)
		|| (awaddr_r == ADDR_PAD_CTRL);
	assign rd_hit = (i_araddr == ADDR_REMAP_STATUS)
		|| (i_araddr == ADDR_SPEED_CTRL) || (i_araddr == ADDR_PAD_CTRL)
		|| (i_araddr == ADDR_PIN_STATUS);
	assign o_arready = !o_rvalid;

	// read data decode
	assign rdata_nxt = (i_araddr == ADDR_REMAP_STATUS) ? {24'h0, remap_r}
		: (i_araddr == ADDR_SPEED_CTRL)
		? {23'h0, speed_fast_r, speed_slow_r}
		: (i_araddr == ADDR_PAD_CTRL) ? {31'h0, osc_pull_r}
		: (i_araddr == ADDR_PIN_STATUS) ? {20'h0, pin_s} : 32'h0;

	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			o_bvalid <= 1'b0;
			o_bresp <= RESP_OKAY;
		end
		else
		begin
			if (i_awvalid && o_awready)
			begin
				aw_hold_r <= 1'b1;
				awaddr_r <= i_awaddr;
			end
			if (i_wvalid && o_wready)
			begin
				w_hold_r <= 1'b1;
				wdata_r <= i_wdata;
				wstrb_r <= i_wstrb;
			end
			if (wr_go)
			begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (o_bvalid && i_bready)
				o_bvalid <= 1'b0;
		end
	end

	// writable control registers
	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			speed_slow_r <= SPEED_SLOW_RESET;
			speed_fast_r <= SPEED_FAST_RESET;
			osc_pull_r <= PAD_PULLUP_RESET;
		end
		else if (wr_go && awaddr_r == ADDR_SPEED_CTRL)
		begin
			if (wstrb_r[0])
				speed_slow_r <= wdata_r[7:0];
			if (wstrb_r[1])
				speed_fast_r <= wdata_r[8];
		end
		else if (wr_go && awaddr_r == ADDR_PAD_CTRL && wstrb_r[0])
			osc_pull_r <= wdata_r[0];
	end

	// axi read channel
	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0;
			o_rresp <= RESP_OKAY;
		end
		else if (i_arvalid && o_arready)
		begin
			o_rvalid <= 1'b1;
			o_rdata <= rdata_nxt;
			o_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (o_rvalid && i_rready)
			o_rvalid <= 1'b0;
	end

endmodule

// ===== bench/pin_remap_properties.sv
`timescale 1ns/1ps
// watches routing, pad control and bus answers at the top ports
module pin_remap_checker
	import pin_remap_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic o_rvalid,
	input wire logic [1:0] o_rresp,
	input wire logic [31:0] o_rdata,
	input wire pin_drive_type i_gpio_a3,
	input wire alt_out_type i_gp_timer_b_channel1,
	input wire alt_out_type i_gp_timer_a_channel3,
	input wire pin_drive_type o_pad_a3,
	input wire logic i_pin_port_d_bit7,
	input wire logic i_port_d_bit7_int_en,
	input wire logic o_top_level_interrupt,
	input wire logic o_port_d_bit7_port_int,
	input wire logic i_halt,
	input wire logic i_hse_wakeup,
	input wire logic i_hse_off,
	input wire logic i_osc_pullup_option,
	input wire logic o_oscillator_input_pad_in_en,
	input wire logic o_oscillator_input_pad_out_en,
	input wire logic o_oscillator_input_pad_pullup,
	input wire logic o_debug_data_pin_pullup,
	input wire logic o_debug_data_pin_oe
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);

	// pin edge while enabled, then a single-cycle pulse
	sequence pin_edge;
		i_port_d_bit7_int_en && $changed(i_pin_port_d_bit7);
	endsequence
	sequence tli_pulse;
		o_top_level_interrupt ##1 !o_top_level_interrupt;
	endsequence

	a_tli_pulse: assert property (pin_edge |-> ##[1:4] tli_pulse)
		else $error("top level interrupt pulse missing");
	a_no_port_int: assert property (!o_port_d_bit7_port_int)
		else $error("port interrupt raised from top level pin");
	a_debug_pull: assert property (
		o_debug_data_pin_pullup && !o_debug_data_pin_oe)
		else $error("debug pin not pulled-up input");
	a_osc_path_off: assert property (i_halt |->
		!o_oscillator_input_pad_in_en && !o_oscillator_input_pad_out_en)
		else $error("oscillator pad path open in halt");
	a_osc_wake_pull: assert property (
		i_halt && i_hse_wakeup |-> !o_oscillator_input_pad_pullup)
		else $error("oscillator pad pull-up on with wakeup clock");
	a_osc_opt_pull: assert property (
		i_halt && i_hse_off && !i_hse_wakeup
		|-> o_oscillator_input_pad_pullup == i_osc_pullup_option)
		else $error("oscillator pad pull-up ignores option");
	a_gpio_keep: assert property (
		!i_gp_timer_b_channel1.en && !i_gp_timer_a_channel3.en
		|-> o_pad_a3 == i_gpio_a3)
		else $error("port drive lost on idle alternate pin");
	a_unmapped_read: assert property (
		i_arvalid && o_arready && i_araddr[7:4] != 4'h0
		|=> o_rvalid && o_rresp == RESP_SLVERR && o_rdata == 32'h0)
		else $error("unmapped read not refused");
endmodule

bind pin_remap pin_remap_checker chk_i (.*);

// ===== bench/pad_ring_model.sv
`timescale 1ns/1ps
// package pins a3 and d2: driven level, else the weak pull-up wins
module pad_ring_model
	import pin_remap_pkg::*;
(
	input wire pin_drive_type i_pad_a3,
	input wire pin_drive_type i_pad_d2,
	output logic o_pin_a3,
	output logic o_pin_d2
);
	assign o_pin_a3 = i_pad_a3.oe ? i_pad_a3.out : 1'b1;
	assign o_pin_d2 = i_pad_d2.oe ? i_pad_d2.out : 1'b1;
endmodule

// ===== bench/pin_remap_tb.sv
`timescale 1ns/1ps
module pin_remap_tb;
	import pin_remap_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic [7:0] i_remap_option = 8'h00, i_awaddr = 8'h00, i_araddr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic [3:0] i_wstrb = 4'hF;
	logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
	logic i_arvalid = 1'b0, i_rready = 1'b0, i_adc_trigger_en = 1'b0;
	logic i_port_d_bit7_int_en = 1'b0, i_halt = 1'b0, i_hse_wakeup = 1'b0;
	logic i_hse_off = 1'b0, i_osc_pullup_option = 1'b1;
	logic i_break_en, i_ext_trigger_en, i_pin_a3, i_pin_d2, i_pin_d0, i_pin_d3;
	logic i_pin_b3, i_pin_b5, i_pin_b4, i_pin_e3, i_pin_e2, i_pin_e1;
	logic i_pin_e0_unused, i_pin_port_d_bit7;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [1:0] o_bresp, o_rresp;
	logic [31:0] o_rdata;
	logic [7:0] o_speed_class_slow_default_fast;
	logic o_gp_timer_b_channel1_in, o_advanced_timer_break_input;
	logic o_advanced_timer_external_trigger, o_adc_external_trigger;
	logic o_i2c_sda_in, o_i2c_scl_in, o_speed_class_fast_default_fast;
	logic o_debug_data_pin_pullup, o_debug_data_pin_oe, o_port_f_bit4_pullup;
	logic o_top_level_interrupt, o_port_d_bit7_port_int;
	logic o_oscillator_input_pad_in_en, o_oscillator_input_pad_out_en;
	logic o_oscillator_input_pad_pullup;
	pin_drive_type i_gpio_a3, i_gpio_d2, i_gpio_d0, i_gpio_d4, i_gpio_b2;
	pin_drive_type i_gpio_b1, i_gpio_b0, i_gpio_b5, i_gpio_b4, i_gpio_c1;
	pin_drive_type o_pad_a3, o_pad_d2, o_pad_d0, o_pad_d4, o_pad_b2, o_pad_b1;
	pin_drive_type o_pad_b0, o_pad_b5, o_pad_b4, o_pad_e2, o_pad_e1;
	pin_drive_type o_pad_e0, o_pad_c1;
	alt_out_type i_gp_timer_b_channel1, i_gp_timer_a_channel3;
	alt_out_type i_gp_timer_b_channel2, i_gp_timer_a_channel1;
	alt_out_type i_configurable_clock_output, i_beeper_output, i_i2c_sda;
	alt_out_type i_advanced_timer_complement_out1, i_i2c_scl;
	alt_out_type i_advanced_timer_complement_out2;
	alt_out_type i_advanced_timer_complement_out3;
	alt_out_type afn = 3'h0;
	pin_drive_type gp = 2'h0;
	logic [9:0] pins = 10'h1FF;
	logic [7:0] opt;
	int fails = 0, tests_run = 0, cyc = 0;
	logic [31:0] n;

	// peripherals and port drive, timer a ch3, a ch1, b ch2 drive low
	assign {i_gp_timer_b_channel1, i_configurable_clock_output, i_beeper_output,
		i_advanced_timer_complement_out1, i_advanced_timer_complement_out2,
		i_advanced_timer_complement_out3, i_i2c_sda, i_i2c_scl} = {8{afn}};
	assign i_gp_timer_a_channel3 = {afn.en, afn.oe, 1'b0};
	assign i_gp_timer_b_channel2 = {afn.en, afn.oe, 1'b0};
	assign i_gp_timer_a_channel1 = {afn.en, afn.oe, 1'b0};
	assign {i_gpio_a3, i_gpio_d2, i_gpio_d0, i_gpio_d4, i_gpio_b2, i_gpio_b1,
		i_gpio_b0, i_gpio_b5, i_gpio_b4, i_gpio_c1} = {10{gp}};
	assign i_break_en = i_adc_trigger_en;
	assign i_ext_trigger_en = i_adc_trigger_en;
	assign {i_pin_port_d_bit7, i_pin_e0_unused, i_pin_e1, i_pin_e2, i_pin_e3,
		i_pin_b4, i_pin_b5, i_pin_b3, i_pin_d3, i_pin_d0} = pins;

	pin_remap dut (.*);
	pad_ring_model pads (.i_pad_a3(o_pad_a3), .i_pad_d2(o_pad_d2),
		.o_pin_a3(i_pin_a3), .o_pin_d2(i_pin_d2));

	always #50 i_core_clk = ~i_core_clk;

	// hang guard
	always @(posedge i_core_clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			fails++;
			print_verdict();
		end
	end

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task do_reset(input logic [7:0] o);
		@(posedge i_core_clk);
		i_arst_n <= 1'b0;
		i_remap_option <= o;
		repeat (6) @(posedge i_core_clk);
		chk("pf4_pull", o_port_f_bit4_pullup, 1);
		chk("dbg_pin", {o_debug_data_pin_pullup, o_debug_data_pin_oe}, 2);
		chk("speed_rst", {o_speed_class_fast_default_fast,
			o_speed_class_slow_default_fast}, 32'h100);
		i_arst_n <= 1'b1;
		repeat (2) @(posedge i_core_clk);
	endtask

	task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, tb;
		logic [1:0] r;
		@(posedge i_core_clk);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		do
		begin
			@(negedge i_core_clk);
			ta = i_awvalid && o_awready;
			tw = i_wvalid && o_wready;
			tb = o_bvalid;
			r = o_bresp;
			@(posedge i_core_clk);
			if (ta) i_awvalid <= 1'b0;
			if (tw) i_wvalid <= 1'b0;
		end while (!tb);
		i_bready <= 1'b0;
		chk("bresp", r, er);
	endtask

	task axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ta, tr;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge i_core_clk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do
		begin
			@(negedge i_core_clk);
			ta = i_arvalid && o_arready;
			tr = o_rvalid;
			d = o_rdata;
			r = o_rresp;
			@(posedge i_core_clk);
			if (ta) i_arvalid <= 1'b0;
		end while (!tr);
		i_rready <= 1'b0;
		chk("rdata", d, ed);
		chk("rresp", r, er);
	endtask

	// counts top level pulses over eight cycles after a pin toggle
	task tli_count();
		@(posedge i_core_clk);
		pins[9] <= ~pins[9];
		n = 0;
		repeat (8) @(negedge i_core_clk) n += o_top_level_interrupt;
	endtask

	task print_verdict();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		for (int k = 0; k < 2; k++)
		begin
			// default pins high first, remapped pins high second
			@(posedge i_core_clk);
			pins <= k ? 10'h01F : 10'h1E0;
			opt = k ? 8'hFF : 8'h00;
			afn <= 3'h0;
			gp <= 2'h0;
			i_adc_trigger_en <= 1'b0;
			do_reset(opt);
			i_remap_option <= ~opt;
			axr(ADDR_REMAP_STATUS, {24'h0, opt}, RESP_OKAY);
			axr(ADDR_SPEED_CTRL, 32'h100, RESP_OKAY);
			afn <= 3'h7;
			i_adc_trigger_en <= 1'b1;
			repeat (5) @(negedge i_core_clk);
			chk("pad_a3", o_pad_a3, k ? 2'b11 : 2'b10);
			chk("pad_d2", o_pad_d2, k ? 2'b10 : 2'b11);
			chk("pad_d0", o_pad_d0, {1'b1, k[0]});
			chk("pad_d4", o_pad_d4, {1'b1, k[0]});
			chk("pad_b0_b2", {o_pad_b0, o_pad_b1, o_pad_b2}, {6{k[0]}});
			chk("pad_b4_b5", {o_pad_b4, o_pad_b5}, {4{k[0]}});
			chk("adc_trig", o_adc_external_trigger, k[0] & pins[1]);
			chk("ext_trig", o_advanced_timer_external_trigger, k);
			chk("brk_in", o_advanced_timer_break_input, 1);
			chk("tim_b_in", o_gp_timer_b_channel1_in, 1);
			chk("i2c_in", {o_i2c_sda_in, o_i2c_scl_in}, 3);
			chk("pad_e", {o_pad_e2, o_pad_e1, o_pad_e0},
				k ? 0 : 6'h3F);
			axr(ADDR_PIN_STATUS, {20'h0, pins, k ? 2'b01 : 2'b10}, RESP_OKAY);
			@(posedge i_core_clk);
			afn <= 3'h3;
			gp <= 2'h3;
			@(negedge i_core_clk);
			chk("gpio_pass", {o_pad_a3, o_pad_d2, o_pad_d0, o_pad_d4,
				o_pad_b0, o_pad_c1}, 32'hFFF);
		end
		axw(ADDR_SPEED_CTRL, 32'h0A5, RESP_OKAY);
		chk("speed", {o_speed_class_fast_default_fast,
			o_speed_class_slow_default_fast}, 32'h0A5);
		axr(ADDR_SPEED_CTRL, 32'h0A5, RESP_OKAY);
		axr(8'h10, 32'h0, RESP_SLVERR);
		axw(8'h20, 32'h0, RESP_SLVERR);
		@(posedge i_core_clk);
		i_halt <= 1'b1;
		i_hse_wakeup <= 1'b1;
		@(negedge i_core_clk);
		chk("osc_wake", {o_oscillator_input_pad_in_en,
			o_oscillator_input_pad_out_en, o_oscillator_input_pad_pullup}, 0);
		// pad register low, so the halt pull-up must come from the option
		axw(ADDR_PAD_CTRL, 32'h0, RESP_OKAY);
		axr(ADDR_PAD_CTRL, 32'h0, RESP_OKAY);
		@(posedge i_core_clk);
		i_hse_wakeup <= 1'b0;
		i_hse_off <= 1'b1;
		i_osc_pullup_option <= 1'b1;
		@(negedge i_core_clk);
		chk("osc_off", o_oscillator_input_pad_pullup, 1);
		@(posedge i_core_clk);
		i_halt <= 1'b0;
		@(negedge i_core_clk);
		chk("osc_run", {o_oscillator_input_pad_in_en,
			o_oscillator_input_pad_out_en, o_oscillator_input_pad_pullup}, 6);
		@(posedge i_core_clk);
		i_port_d_bit7_int_en <= 1'b1;
		tli_count();
		chk("tli_on", n, 1);
		@(posedge i_core_clk);
		i_port_d_bit7_int_en <= 1'b0;
		tli_count();
		chk("tli_off", n, 0);
		// break alone on d0: timer b ch2 leaves, port drive stays
		@(posedge i_core_clk);
		afn <= 3'h7;
		do_reset(8'h08);
		@(negedge i_core_clk);
		chk("brk_d0_pad", o_pad_d0, 3);
		chk("brk_d0_in", o_advanced_timer_break_input, pins[0]);
		chk("cco_e0", o_pad_e0, 3);
		print_verdict();
	end
endmodule
